// ---- inc/tcie_pkg.sv ----
// Package for the timer compare, interval and event counter block
package tcie_pkg;
  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_INPUT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0C;
  localparam logic [7:0] ADDR_DUTY = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTRL_A_ENABLE_BIT = 7;
  localparam int CTRL_B_SRC_BIT = 5;
  localparam int CTRL_B_MODE_LSB = 0;
  localparam int CTRL_B_OE0_BIT = 3;
  localparam int CTRL_B_OE1_BIT = 4;
  localparam int MODE_W = 3;
  localparam int STAT_ARM_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  // ------------------------------------------------------------
  // Modes and reset values
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_EVENT = 3'h1;
  localparam logic [2:0] MODE_EXT_TRIG = 3'h2;
  localparam logic [2:0] MODE_PWM = 3'h6;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- design/tcie_timer.sv ----
// Timer channel with buffered compares, interval and event count modes
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module tcie_timer
#(
  parameter int CNT_W = 16
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic count_clk_ext,
  input wire logic event_trigger_pin,
  output logic match0_irq,
  output logic match1_irq,
  output logic compare0_out_pin,
  output logic compare1_out_pin
);
  // ------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ------------------------------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic wr_go;
  logic wr_hit;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  assign wr_go = (aw_held_r || (s_axi_awvalid && s_axi_awready))
    && (w_held_r || (s_axi_wvalid && s_axi_wready));
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= tcie_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_addr_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      // Hold only what was really taken, or the address would be lost
      aw_held_r <= wr_go ? 1'b0
        : (aw_held_r || (s_axi_awvalid && s_axi_awready));
      w_held_r <= wr_go ? 1'b0
        : (w_held_r || (s_axi_wvalid && s_axi_wready));
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? tcie_pkg::RESP_OKAY : tcie_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] input_ctrl_reg_r;
  logic [CNT_W-1:0] compare_period_reg_r;
  logic [CNT_W-1:0] compare_duty_reg_r;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_in;
  logic wr_period;
  logic wr_duty;

  assign wr_ctrl_a = wr_go && wr_addr == tcie_pkg::ADDR_CTRL_A;
  assign wr_ctrl_b = wr_go && wr_addr == tcie_pkg::ADDR_CTRL_B;
  assign wr_in = wr_go && wr_addr == tcie_pkg::ADDR_INPUT_CTRL;
  assign wr_period = wr_go && wr_addr == tcie_pkg::ADDR_PERIOD;
  assign wr_duty = wr_go && wr_addr == tcie_pkg::ADDR_DUTY;
  assign wr_hit = wr_ctrl_a || wr_ctrl_b || wr_in || wr_period || wr_duty
    || wr_addr == tcie_pkg::ADDR_COUNT || wr_addr == tcie_pkg::ADDR_STATUS;

  logic counter_enable_bit;
  logic count_source_select;
  logic [2:0] mode_sel;
  logic out0_enable;
  logic out1_enable;
  logic reload_mode;

  assign counter_enable_bit = ctrl_a_r[tcie_pkg::CTRL_A_ENABLE_BIT];
  assign count_source_select = ctrl_b_r[tcie_pkg::CTRL_B_SRC_BIT];
  assign mode_sel = ctrl_b_r[tcie_pkg::CTRL_B_MODE_LSB +: tcie_pkg::MODE_W];
  assign out0_enable = ctrl_b_r[tcie_pkg::CTRL_B_OE0_BIT];
  assign out1_enable = ctrl_b_r[tcie_pkg::CTRL_B_OE1_BIT];
  assign reload_mode = mode_sel == tcie_pkg::MODE_EXT_TRIG
    || mode_sel == tcie_pkg::MODE_PWM;

  // Byte lanes honoured; 16-bit compares use lanes 0 and 1
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_a_r <= 8'h00;
      ctrl_b_r <= 8'h00;
      input_ctrl_reg_r <= 8'h00;
      compare_period_reg_r <= tcie_pkg::CMP_RESET;
      compare_duty_reg_r <= tcie_pkg::CMP_RESET;
    end
    else
    begin
      if (wr_ctrl_a && wr_strb[0])
        ctrl_a_r <= wr_data[7:0];
      if (wr_ctrl_b && wr_strb[0])
        ctrl_b_r <= wr_data[7:0];
      if (wr_in && wr_strb[0])
        input_ctrl_reg_r <= wr_data[7:0];
      if (wr_period && wr_strb[0])
        compare_period_reg_r[7:0] <= wr_data[7:0];
      if (wr_period && wr_strb[1])
        compare_period_reg_r[15:8] <= wr_data[15:8];
      if (wr_duty && wr_strb[0])
        compare_duty_reg_r[7:0] <= wr_data[7:0];
      if (wr_duty && wr_strb[1])
        compare_duty_reg_r[15:8] <= wr_data[15:8];
    end
  end

  // ------------------------------------------------------------
  // Count clock and counter
  // ------------------------------------------------------------
  logic ext_prev_r;
  logic evt_prev_r;
  logic ext_tick;
  logic evt_tick;
  logic tick;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] buf0_r;
  logic [CNT_W-1:0] buf1_r;
  logic reload_armed_r;
  logic match0;
  logic match1;

  // Rising edges; the pin inputs are already synchronous to clk
  assign ext_tick = count_clk_ext && !ext_prev_r;
  assign evt_tick = event_trigger_pin && !evt_prev_r;
  // Event mode ignores the source select bit
  assign tick = (mode_sel == tcie_pkg::MODE_EVENT) ? evt_tick
    : (count_source_select ? ext_tick : 1'b1);
  // Matches only on a counting tick so the period is buf0_r+1 ticks
  assign match0 = counter_enable_bit && tick && cnt_r == buf0_r;
  assign match1 = counter_enable_bit && tick && cnt_r == buf1_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ext_prev_r <= 1'b0;
      evt_prev_r <= 1'b0;
      cnt_r <= tcie_pkg::CNT_ZERO;
    end
    else
    begin
      ext_prev_r <= count_clk_ext;
      evt_prev_r <= event_trigger_pin;
      if (!counter_enable_bit)
        cnt_r <= tcie_pkg::CNT_ZERO;
      else if (match0)
        cnt_r <= tcie_pkg::CNT_ZERO;
      else if (tick)
        cnt_r <= cnt_r + tcie_pkg::CNT_ONE;
    end
  end

  // ------------------------------------------------------------
  // Compare buffers: anytime write or armed reload
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      buf0_r <= tcie_pkg::CMP_RESET;
      buf1_r <= tcie_pkg::CMP_RESET;
      reload_armed_r <= 1'b0;
    end
    else if (!reload_mode || !counter_enable_bit)
    begin
      // Stopped timer loads directly so a restart uses fresh values
      buf0_r <= compare_period_reg_r;
      buf1_r <= compare_duty_reg_r;
      reload_armed_r <= 1'b0;
    end
    else
    begin
      if (match0 && reload_armed_r)
      begin
        buf0_r <= compare_period_reg_r;
        buf1_r <= compare_duty_reg_r;
      end
      // A new duty write wins over the clearing reload
      if (wr_duty)
        reload_armed_r <= 1'b1;
      else if (match0)
        reload_armed_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Interrupts and output pins
  // ------------------------------------------------------------
  logic irq0_r;
  logic irq1_r;
  logic tog0_r;
  logic tog1_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq0_r <= 1'b0;
      irq1_r <= 1'b0;
      tog0_r <= 1'b0;
      tog1_r <= 1'b0;
    end
    else
    begin
      irq0_r <= match0;
      irq1_r <= match1;
      if (!counter_enable_bit)
        tog0_r <= 1'b0;
      else if (match0)
        tog0_r <= !tog0_r;
      if (!counter_enable_bit)
        tog1_r <= 1'b0;
      else if (match1)
        tog1_r <= !tog1_r;
    end
  end

  assign match0_irq = irq0_r;
  assign match1_irq = irq1_r;
  assign compare0_out_pin = out0_enable && tog0_r;
  assign compare1_out_pin = out1_enable && tog1_r;

  // ------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rd_mux;
  logic rd_hit;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_comb
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      tcie_pkg::ADDR_CTRL_A: rd_mux[7:0] = ctrl_a_r;
      tcie_pkg::ADDR_CTRL_B: rd_mux[7:0] = ctrl_b_r;
      tcie_pkg::ADDR_INPUT_CTRL: rd_mux[7:0] = input_ctrl_reg_r;
      tcie_pkg::ADDR_PERIOD: rd_mux[15:0] = compare_period_reg_r;
      tcie_pkg::ADDR_DUTY: rd_mux[15:0] = compare_duty_reg_r;
      tcie_pkg::ADDR_COUNT: rd_mux[15:0] = cnt_r;
      tcie_pkg::ADDR_STATUS:
      begin
        rd_mux[tcie_pkg::STAT_ARM_BIT] = reload_armed_r;
        rd_mux[tcie_pkg::STAT_RUN_BIT] = counter_enable_bit;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= tcie_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? tcie_pkg::RESP_OKAY : tcie_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end
endmodule

// ---- test/tcie_timer_assertions.sv ----
// Checker for the timer channel bus handshakes and match outputs
`timescale 1ns/1ps
module tcie_timer_assertions
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic match0_irq,
  input wire logic match1_irq,
  input wire logic compare0_out_pin,
  input wire logic compare1_out_pin
);
  // ----------------------------------------
  // Relations
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_write_block: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no rvalid");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  a_pin0_match: assert property ($rose(compare0_out_pin) |->
    ##[0:1] match0_irq) else $error("pin0 rose without match");
  a_pin1_match: assert property ($rose(compare1_out_pin) |->
    ##[0:1] match1_irq) else $error("pin1 rose without match");
  a_reset_quiet: assert property ($fell(sys_rst) |-> !match0_irq &&
    !match1_irq && !s_axi_bvalid && !s_axi_rvalid && !compare0_out_pin &&
    !compare1_out_pin) else $error("outputs busy after reset");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_both_match: cover property (match0_irq && match1_irq);
  c_pin1: cover property ($rose(compare1_out_pin));
endmodule
bind tcie_timer tcie_timer_assertions tcie_timer_assertions_i (
  .clk(clk),
  .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .match0_irq(match0_irq),
  .match1_irq(match1_irq),
  .compare0_out_pin(compare0_out_pin),
  .compare1_out_pin(compare1_out_pin)
);

// ---- test/tcie_event_src.sv ----
// Event pin source: one-cycle pulses every spacing cycles while run
`timescale 1ns/1ps
module tcie_event_src
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [3:0] spacing,
  output logic event_trigger_pin
);
  logic [3:0] cnt_r;
  // ----------------------------------------
  // Pulse train, quiet low between events
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || !run)
    begin
      cnt_r <= 4'h0;
      event_trigger_pin <= 1'b0;
    end
    else
    begin
      cnt_r <= (cnt_r == spacing - 4'h1) ? 4'h0 : cnt_r + 4'h1;
      event_trigger_pin <= (cnt_r == 4'h0);
    end
  end
endmodule

// ---- test/tcie_timer_tb.sv ----
// Self-checking bench for the timer channel
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tcie_timer_tb;
  logic clk, sys_rst, run, count_clk_ext, event_trigger_pin;
  logic p0_last = 1'b0;
  logic p1_last = 1'b0;
  logic [7:0] n1 = 8'h00;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, spacing;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, match0_irq, match1_irq;
  logic compare0_out_pin, compare1_out_pin;
  logic [33:0] q[$];
  logic [25:0] qp[$];
  logic [33:0] e;
  logic [25:0] ep;
  logic [15:0] gap = 16'h0000;
  int err_count, compares, i;
  integer seed = 32'h647565b2;
  tcie_timer tcie_timer_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .count_clk_ext(count_clk_ext),
    .event_trigger_pin(event_trigger_pin),
    .match0_irq(match0_irq),
    .match1_irq(match1_irq),
    .compare0_out_pin(compare0_out_pin),
    .compare1_out_pin(compare1_out_pin)
  );
  tcie_event_src tcie_event_src_i (.clk(clk), .sys_rst(sys_rst), .run(run),
    .spacing(spacing), .event_trigger_pin(event_trigger_pin));
  // ----------------------------------------
  // Clock, noise on the unused clock pin, watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) count_clk_ext <= 1'($random(seed));
  initial
  begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  task tally_and_finish;
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Bus master and notes
  // ----------------------------------------
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  // Skips one pulse so the measured gap never spans a restart
  // t holds the expected toggles of pin 0 and pin 1 per period
  task periods(input logic [1:0] t, input logic [7:0] n,
    input logic [15:0] g);
    @(posedge clk iff match0_irq);
    @(posedge clk);
    qp.push_back({t, n, g});
    qp.push_back({t, n, g});
    while (qp.size() != 0)
      @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    if (s_axi_bvalid && s_axi_bready)
    begin
      e = q.pop_front();
      `CHK("write response", e, {s_axi_bresp, 32'h0})
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      e = q.pop_front();
      `CHK("read data", e, {s_axi_rresp, s_axi_rdata})
    end
    if (match1_irq)
      n1++;
    if (match0_irq)
    begin
      if (qp.size() > 0)
      begin
        ep = qp.pop_front();
        `CHK("match period", ep, {p0_last ^ compare0_out_pin, p1_last ^ compare1_out_pin, n1, gap})
      end
      gap = 16'h0000;
      n1 = 8'h00;
      p0_last = compare0_out_pin;
      p1_last = compare1_out_pin;
    end
    gap++;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, run, spacing} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 8; i++)
      axi_rd(8'(i * 4), 32'h0, (i == 7) ? 2'h2 : 2'h0);
    axi_wr(8'h1C, 32'($random(seed)), 2'h2);
    axi_wr(tcie_pkg::ADDR_CTRL_B, 32'h00000018, 2'h0);
    axi_wr(tcie_pkg::ADDR_PERIOD, 32'h00000009, 2'h0);
    axi_wr(tcie_pkg::ADDR_DUTY, 32'h00000009, 2'h0);
    axi_wr(tcie_pkg::ADDR_CTRL_A, 32'h00000080, 2'h0);
    periods(2'b11, 8'h01, 16'h000A);
    axi_wr(tcie_pkg::ADDR_DUTY, 32'h0000FFFF, 2'h0);
    axi_wr(tcie_pkg::ADDR_PERIOD, {16'($random(seed)), 16'h0013}, 2'h0);
    periods(2'b10, 8'h00, 16'h0014);
    axi_rd(tcie_pkg::ADDR_PERIOD, 32'h00000013, 2'h0);
    axi_wr(tcie_pkg::ADDR_CTRL_A, 32'h0, 2'h0);
    axi_rd(tcie_pkg::ADDR_COUNT, 32'h0, 2'h0);
    axi_wr(tcie_pkg::ADDR_CTRL_B, 32'h0, 2'h0);
    axi_wr(tcie_pkg::ADDR_PERIOD, 32'h00000009, 2'h0);
    axi_wr(tcie_pkg::ADDR_DUTY, 32'h00000004, 2'h0);
    axi_wr(tcie_pkg::ADDR_CTRL_A, 32'h00000080, 2'h0);
    periods(2'b00, 8'h01, 16'h000A);
    axi_wr(tcie_pkg::ADDR_CTRL_A, 32'h0, 2'h0);
    spacing <= 4'h2 + 4'($random(seed) & 3);
    axi_wr(tcie_pkg::ADDR_INPUT_CTRL, 32'h0, 2'h0);
    axi_wr(tcie_pkg::ADDR_CTRL_B, 32'h00000031, 2'h0);
    axi_wr(tcie_pkg::ADDR_PERIOD, 32'h00000003, 2'h0);
    axi_wr(tcie_pkg::ADDR_DUTY, 32'h00000003, 2'h0);
    run <= 1'b1;
    axi_wr(tcie_pkg::ADDR_CTRL_A, 32'h00000080, 2'h0);
    periods(2'b01, 8'h01, {10'h000, spacing, 2'h0});
    axi_wr(tcie_pkg::ADDR_CTRL_A, 32'h0, 2'h0);
    run <= 1'b0;
    axi_wr(tcie_pkg::ADDR_CTRL_B, 32'h00000012, 2'h0);
    axi_wr(tcie_pkg::ADDR_PERIOD, 32'h00000009, 2'h0);
    axi_wr(tcie_pkg::ADDR_DUTY, 32'h00000009, 2'h0);
    axi_wr(tcie_pkg::ADDR_CTRL_A, 32'h00000080, 2'h0);
    periods(2'b01, 8'h01, 16'h000A);
    axi_wr(tcie_pkg::ADDR_PERIOD, 32'h00000013, 2'h0);
    periods(2'b01, 8'h01, 16'h000A);
    axi_wr(tcie_pkg::ADDR_CTRL_A, 32'h0, 2'h0);
    axi_wr(tcie_pkg::ADDR_CTRL_B, 32'h00000016, 2'h0);
    axi_wr(tcie_pkg::ADDR_PERIOD, 32'h00000009, 2'h0);
    axi_wr(tcie_pkg::ADDR_CTRL_A, 32'h00000080, 2'h0);
    axi_wr(tcie_pkg::ADDR_PERIOD, 32'h00000013, 2'h0);
    axi_wr(tcie_pkg::ADDR_DUTY, 32'h00000009, 2'h0);
    periods(2'b01, 8'h01, 16'h0014);
    tally_and_finish();
  end
endmodule
